// >>> design/hotswap_protect_sense_cfg_regs.svh
// Command codes, field positions and reset values of the protection config group
`ifndef HOTSWAP_PROTECT_SENSE_CFG_REGS_SVH
`define HOTSWAP_PROTECT_SENSE_CFG_REGS_SVH
`define CMD_INPUT_VOLTAGE_SENSE_SCALE 8'he4
`define CMD_TEMPERATURE_SENSE_TRIM 8'he5
`define CMD_PROTECTION_ENABLE_CONFIG 8'he6
`define SCALE_FIELD_MASK 16'h07ff
`define PROTECT_WRITABLE_MASK 16'h55ab
`define SCALE_RESET 11'h000
`define TRIM_RESET 16'h0000
`define PROTECT_RESET 16'h0000
`define SCALE_NUMERATOR 16'h1400
`define TEMP_VOLT_MULT 16'h0140
`define TEMP_GAIN_SHIFT 8
`define BIT_CTRL_OTP 14
`define BIT_ASSERT_HOLD 12
`define BIT_MAX_SS 10
`define BIT_RECORD 8
`define BIT_FAULT_KIND 7
`define BIT_TOTAL_OC 5
`define BIT_FOLLOWER_WATCH 3
`define BIT_SENSED_OT 1
`define BIT_VIN_PROT 0
`endif

// >>> design/protect_cfg_pkg.sv
// Types shared by the protection configuration block
package protect_cfg_pkg;
    typedef logic [7:0] cmd_code_t;
    typedef logic [15:0] word_t;
    typedef struct packed {
        logic ctrl_otp;
        logic max_ss;
        logic total_oc;
        logic follower_fault;
        logic sensed_ot;
        logic vin_prot;
    } raw_fault_s;
endpackage : protect_cfg_pkg

// >>> design/temp_calc_if.sv
// Carries the temperature conversion inputs and result
`timescale 1ns/1ns
interface temp_calc_if;
    logic [11:0] sense_code;
    logic [15:0] trim;
    logic signed [23:0] temp_c;
    modport calc (input sense_code, input trim, output temp_c);
    modport user (output sense_code, output trim, input temp_c);
endinterface : temp_calc_if

// >>> design/temp_calc.sv
// Converts the sensed temperature voltage into degrees using the trim word
`timescale 1ns/1ns
`include "hotswap_protect_sense_cfg_regs.svh"
module temp_calc (
    input wire logic core_clk,
    input wire logic srst,
    temp_calc_if.calc tc
);
    import protect_cfg_pkg::*;
    logic signed [23:0] nxt_temp;
    logic signed [15:0] scaled;
    always_comb begin
        // sense_code is volts in 1/4096 V steps, so volts*320 = code*320/4096
        // Product needs 21 bits, so widen before multiplying
        scaled = 16'(($signed(32'({4'h0, tc.sense_code})) * $signed(32'(`TEMP_VOLT_MULT))) >>> 12)
            + 16'($signed(tc.trim[15:8]));
        nxt_temp = 24'((32'(scaled) * $signed({24'h000000, tc.trim[7:0]})) >>> `TEMP_GAIN_SHIFT);
    end
    always_ff @(posedge core_clk) begin
        if (srst) begin
            tc.temp_c <= '0;
        end else begin
            tc.temp_c <= nxt_temp;
        end
    end
    temp_div_a: assert property (@(posedge core_clk) disable iff (srst)
        1 |=> tc.temp_c == $past(nxt_temp)) else $error("temperature result lags");
endmodule : temp_calc

// >>> design/hotswap_protect_sense_cfg.sv
// Configuration register group for sense scale, temperature trim and protection enables
`timescale 1ns/1ns
`include "hotswap_protect_sense_cfg_regs.svh"
module hotswap_protect_sense_cfg (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic cmd_wr,
    input wire logic cmd_rd,
    input wire protect_cfg_pkg::cmd_code_t cmd_code,
    input wire protect_cfg_pkg::word_t cmd_wdata,
    output protect_cfg_pkg::word_t cmd_rdata,
    output logic cmd_ack,
    output logic cmd_invalid,
    input wire logic [11:0] temp_sense_voltage,
    output logic signed [23:0] temp_reading,
    input wire protect_cfg_pkg::raw_fault_s fault_raw,
    input wire logic nvm_record_busy,
    input wire logic fault_event,
    output logic nvm_record_req,
    output protect_cfg_pkg::raw_fault_s fault_assert,
    input wire logic fault_ok_line,
    input wire logic fault_kind_pin,
    output logic follower_fault_status,
    output logic fault_kind_latched,
    output logic [10:0] input_voltage_sense_scale
);
    import protect_cfg_pkg::*;
    word_t trim_ff;
    word_t protect_ff;
    logic [10:0] scale_ff;
    word_t nxt_rdata;
    logic hit;
    raw_fault_s gated;
    temp_calc_if tci ();

    // Write path; masks drop reserved bits so they never store
    always_ff @(posedge core_clk) begin
        if (srst) begin
            scale_ff <= `SCALE_RESET;
            trim_ff <= `TRIM_RESET;
            protect_ff <= `PROTECT_RESET;
        end else if (cmd_wr) begin
            if (cmd_code == `CMD_INPUT_VOLTAGE_SENSE_SCALE)
                scale_ff <= 11'(cmd_wdata & `SCALE_FIELD_MASK);
            if (cmd_code == `CMD_TEMPERATURE_SENSE_TRIM)
                trim_ff <= cmd_wdata;
            if (cmd_code == `CMD_PROTECTION_ENABLE_CONFIG)
                protect_ff <= cmd_wdata & `PROTECT_WRITABLE_MASK;
        end
    end

    always_comb begin
        hit = 1'b1;
        unique case (cmd_code)
            `CMD_INPUT_VOLTAGE_SENSE_SCALE: nxt_rdata = {5'h00, scale_ff};
            `CMD_TEMPERATURE_SENSE_TRIM: nxt_rdata = trim_ff;
            `CMD_PROTECTION_ENABLE_CONFIG: nxt_rdata = protect_ff;
            default: begin
                nxt_rdata = 16'h0000;
                hit = 1'b0;
            end
        endcase
    end

    // Read data registered so it holds steady for the serial shifter
    always_ff @(posedge core_clk) begin
        if (srst) begin
            cmd_rdata <= 16'h0000;
            cmd_ack <= 1'b0;
            cmd_invalid <= 1'b0;
        end else begin
            cmd_rdata <= cmd_rd ? nxt_rdata : cmd_rdata;
            cmd_ack <= (cmd_rd | cmd_wr) & hit;
            cmd_invalid <= (cmd_rd | cmd_wr) & ~hit;
        end
    end

    assign input_voltage_sense_scale = scale_ff;

    assign tci.sense_code = temp_sense_voltage;
    assign tci.trim = trim_ff;
    assign temp_reading = tci.temp_c;
    temp_calc u_temp_calc (
        .core_clk(core_clk),
        .srst(srst),
        .tc(tci)
    );

    // Hold-off, when enabled, blocks every fault_assert bit while the record is being written
    logic hold_off;
    assign hold_off = protect_ff[`BIT_ASSERT_HOLD] & nvm_record_busy;
    always_comb begin
        gated.ctrl_otp = fault_raw.ctrl_otp & protect_ff[`BIT_CTRL_OTP];
        gated.max_ss = fault_raw.max_ss & protect_ff[`BIT_MAX_SS];
        gated.total_oc = fault_raw.total_oc & protect_ff[`BIT_TOTAL_OC];
        gated.follower_fault = ~fault_ok_line & protect_ff[`BIT_FOLLOWER_WATCH];
        gated.sensed_ot = fault_raw.sensed_ot & protect_ff[`BIT_SENSED_OT];
        gated.vin_prot = fault_raw.vin_prot & protect_ff[`BIT_VIN_PROT];
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            fault_assert <= '0;
        end else begin
            fault_assert <= hold_off ? '0 : gated;
        end
    end

    // Follower status is sticky until the watch is disabled
    always_ff @(posedge core_clk) begin
        if (srst) begin
            follower_fault_status <= 1'b0;
        end else if (gated.follower_fault) begin
            follower_fault_status <= 1'b1;
        end else if (!protect_ff[`BIT_FOLLOWER_WATCH]) begin
            follower_fault_status <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            fault_kind_latched <= 1'b0;
        end else if (protect_ff[`BIT_FAULT_KIND] & gated.follower_fault) begin
            fault_kind_latched <= fault_kind_pin;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            nvm_record_req <= 1'b0;
        end else begin
            nvm_record_req <= fault_event & protect_ff[`BIT_RECORD];
        end
    end

    scale_zero_a: assert property (@(posedge core_clk) disable iff (srst)
        cmd_ack |-> cmd_rdata[15:11] == 5'h00 || $past(cmd_code) != `CMD_INPUT_VOLTAGE_SENSE_SCALE)
        else $error("scale high bits nonzero");
    cfg_top_zero_a: assert property (@(posedge core_clk) disable iff (srst)
        protect_ff[15] == 1'b0) else $error("config bit 15 stored");
    scale_store_a: assert property (@(posedge core_clk) disable iff (srst)
        cmd_wr && cmd_code == `CMD_INPUT_VOLTAGE_SENSE_SCALE |=> input_voltage_sense_scale == $past(cmd_wdata[10:0]))
        else $error("scale not stored");
    ctrl_otp_gate_a: assert property (@(posedge core_clk) disable iff (srst)
        fault_raw.ctrl_otp && !protect_ff[`BIT_CTRL_OTP] |=> !fault_assert.ctrl_otp)
        else $error("controller otp not gated");
    hold_off_a: assert property (@(posedge core_clk) disable iff (srst)
        hold_off |=> fault_assert == '0) else $error("protection during record");
    max_ss_a: assert property (@(posedge core_clk) disable iff (srst)
        fault_raw.max_ss && protect_ff[`BIT_MAX_SS] && !hold_off |=> fault_assert.max_ss)
        else $error("soft-start fault missing");
    record_req_a: assert property (@(posedge core_clk) disable iff (srst)
        nvm_record_req |-> $past(fault_event) && $past(protect_ff[`BIT_RECORD]))
        else $error("record without enable");
    kind_hold_a: assert property (@(posedge core_clk) disable iff (srst)
        !protect_ff[`BIT_FAULT_KIND] |=> $stable(fault_kind_latched))
        else $error("fault kind moved while off");
    total_oc_a: assert property (@(posedge core_clk) disable iff (srst)
        fault_raw.total_oc && protect_ff[`BIT_TOTAL_OC] && !hold_off |=> fault_assert.total_oc)
        else $error("total oc missing");
    follower_a: assert property (@(posedge core_clk) disable iff (srst)
        !fault_ok_line && protect_ff[`BIT_FOLLOWER_WATCH] |=> follower_fault_status)
        else $error("follower fault missed");
    sensed_ot_a: assert property (@(posedge core_clk) disable iff (srst)
        fault_assert.sensed_ot |-> $past(protect_ff[`BIT_SENSED_OT]))
        else $error("sensed ot not gated");
    vin_prot_a: assert property (@(posedge core_clk) disable iff (srst)
        fault_assert.vin_prot |-> $past(protect_ff[`BIT_VIN_PROT]) && $past(fault_raw.vin_prot))
        else $error("vin protection not gated");
endmodule : hotswap_protect_sense_cfg

// >>> tb/pmbus_host_model.sv
// Host stand-in that issues command strobes to the configuration group
`timescale 1ns/1ns
module pmbus_host_model (
    input wire logic core_clk,
    output logic cmd_wr,
    output logic cmd_rd,
    output protect_cfg_pkg::cmd_code_t cmd_code,
    output protect_cfg_pkg::word_t cmd_wdata,
    input wire protect_cfg_pkg::word_t cmd_rdata,
    input wire logic cmd_ack,
    input wire logic cmd_invalid
);
    import protect_cfg_pkg::*;
    // Offset -49 and gain 92, rounded from the sense calibration
    localparam word_t trim_word = 16'hcf5c;
    // Reserved config bits go out as zero in the t_gate config writes
    localparam word_t cfg_legal = 16'h55ab;
    initial begin
        cmd_wr = 1'b0;
        cmd_rd = 1'b0;
        cmd_code = 8'h00;
        cmd_wdata = 16'h0000;
    end
    task automatic wr(input cmd_code_t c, input word_t d, output logic ack, output logic inv);
        @(posedge core_clk);
        cmd_wr <= 1'b1;
        cmd_code <= c;
        cmd_wdata <= d;
        @(posedge core_clk);
        cmd_wr <= 1'b0;
        // Released data does not keep the last value
        cmd_wdata <= ~d;
        #1;
        ack = cmd_ack;
        inv = cmd_invalid;
    endtask : wr
    task automatic rd(input cmd_code_t c, output word_t d, output logic ack, output logic inv);
        @(posedge core_clk);
        cmd_rd <= 1'b1;
        cmd_code <= c;
        @(posedge core_clk);
        cmd_rd <= 1'b0;
        #1;
        d = cmd_rdata;
        ack = cmd_ack;
        inv = cmd_invalid;
    endtask : rd
endmodule : pmbus_host_model

// >>> tb/hotswap_protect_sense_cfg_tb.sv
// Self-checking bench for the protection configuration group
`timescale 1ns/1ns
`include "hotswap_protect_sense_cfg_regs.svh"
module hotswap_protect_sense_cfg_tb;
    import protect_cfg_pkg::*;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic cmd_wr, cmd_rd, cmd_ack, cmd_invalid, nvm_record_req, follower_fault_status, fault_kind_latched;
    cmd_code_t cmd_code;
    word_t cmd_wdata, cmd_rdata;
    logic [11:0] temp_sense_voltage = 12'h000;
    logic signed [23:0] temp_reading;
    raw_fault_s fault_raw = '0;
    raw_fault_s fault_assert;
    logic nvm_record_busy = 1'b0;
    logic fault_event = 1'b0;
    logic fault_ok_line = 1'b1;
    logic fault_kind_pin = 1'b0;
    logic [10:0] input_voltage_sense_scale;
    int miscompares = 0;
    int n_compared = 0;
    int cycles = 0;
    always #4 core_clk = ~core_clk;
    hotswap_protect_sense_cfg dut (.core_clk(core_clk), .srst(srst), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
        .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_ack(cmd_ack),
        .cmd_invalid(cmd_invalid), .temp_sense_voltage(temp_sense_voltage), .temp_reading(temp_reading),
        .fault_raw(fault_raw), .nvm_record_busy(nvm_record_busy), .fault_event(fault_event),
        .nvm_record_req(nvm_record_req), .fault_assert(fault_assert), .fault_ok_line(fault_ok_line),
        .fault_kind_pin(fault_kind_pin), .follower_fault_status(follower_fault_status),
        .fault_kind_latched(fault_kind_latched), .input_voltage_sense_scale(input_voltage_sense_scale));
    pmbus_host_model host (.core_clk(core_clk), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_code(cmd_code),
        .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_ack(cmd_ack), .cmd_invalid(cmd_invalid));
    task automatic chk(input string name, input logic [23:0] got, input logic [23:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : settle
    task automatic t_regs();
        logic a, i;
        word_t d;
        host.wr(`CMD_INPUT_VOLTAGE_SENSE_SCALE, 16'hffff, a, i);
        chk("scale ack", a, 1'b1);
        host.rd(`CMD_INPUT_VOLTAGE_SENSE_SCALE, d, a, i);
        chk("scale read", d, 16'h07ff);
        chk("scale out", input_voltage_sense_scale, 11'h7ff);
        host.wr(`CMD_PROTECTION_ENABLE_CONFIG, 16'hffff, a, i);
        host.rd(`CMD_PROTECTION_ENABLE_CONFIG, d, a, i);
        chk("config read", d, 16'h55ab);
        host.wr(`CMD_TEMPERATURE_SENSE_TRIM, 16'ha5c3, a, i);
        host.rd(`CMD_TEMPERATURE_SENSE_TRIM, d, a, i);
        chk("trim read", d, 16'ha5c3);
        host.wr(8'he7, 16'h1234, a, i);
        chk("unknown wr", {a, i}, 2'b01);
        host.rd(8'he7, d, a, i);
        chk("unknown rd", {d, i}, 17'h00001);
        $display("test regs done");
    endtask : t_regs
    task automatic t_temp();
        logic a, i;
        host.wr(`CMD_TEMPERATURE_SENSE_TRIM, host.trim_word, a, i);
        @(posedge core_clk);
        temp_sense_voltage <= 12'h800;
        settle(2);
        chk("temp half volt", temp_reading, 24'd39);
        temp_sense_voltage <= 12'h000;
        settle(2);
        chk("temp zero volt", temp_reading, 24'hffffee);
        $display("test temp done");
    endtask : t_temp
    task automatic t_gate();
        logic a, i;
        logic [15:0] w[5] = '{16'h4000, 16'h0400, 16'h0020, 16'h0002, 16'h0001};
        logic [5:0] e[5] = '{6'h20, 6'h10, 6'h08, 6'h02, 6'h01};
        fault_raw <= 6'h3f;
        for (int k = 0; k < 5; k++) begin
            host.wr(`CMD_PROTECTION_ENABLE_CONFIG, w[k] & host.cfg_legal, a, i);
            settle(2);
            chk("gated fault", fault_assert & 6'h3b, e[k]);
        end
        nvm_record_busy <= 1'b1;
        settle(2);
        chk("no hold", fault_assert & 6'h3b, 6'h01);
        host.wr(`CMD_PROTECTION_ENABLE_CONFIG, 16'h1001, a, i);
        settle(2);
        chk("held off", fault_assert & 6'h3b, 6'h00);
        nvm_record_busy <= 1'b0;
        settle(2);
        chk("hold over", fault_assert & 6'h3b, 6'h01);
        fault_raw <= 6'h00;
        $display("test gate done");
    endtask : t_gate
    task automatic t_record();
        logic a, i;
        for (int k = 1; k >= 0; k--) begin
            host.wr(`CMD_PROTECTION_ENABLE_CONFIG, k ? 16'h0100 : 16'h0000, a, i);
            @(posedge core_clk);
            fault_event <= 1'b1;
            @(posedge core_clk);
            fault_event <= 1'b0;
            #1;
            chk("record req", nvm_record_req, k[0]);
            settle(1);
            chk("record end", nvm_record_req, 1'b0);
        end
        $display("test record done");
    endtask : t_record
    task automatic t_follower();
        logic a, i;
        host.wr(`CMD_PROTECTION_ENABLE_CONFIG, 16'h0088, a, i);
        fault_kind_pin <= 1'b1;
        fault_ok_line <= 1'b0;
        settle(3);
        chk("follower set", follower_fault_status, 1'b1);
        chk("kind latched", fault_kind_latched, 1'b1);
        fault_ok_line <= 1'b1;
        settle(2);
        chk("follower sticky", follower_fault_status, 1'b1);
        host.wr(`CMD_PROTECTION_ENABLE_CONFIG, 16'h0000, a, i);
        fault_ok_line <= 1'b0;
        settle(3);
        chk("follower off", follower_fault_status, 1'b0);
        fault_ok_line <= 1'b1;
        $display("test follower done");
    endtask : t_follower
    task automatic finish_test();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : finish_test
    // Whole run needs under a hundred cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            finish_test();
        end
    end
    initial begin
        repeat (4) @(posedge core_clk);
        srst <= 1'b0;
        t_regs();
        t_temp();
        t_gate();
        t_record();
        t_follower();
        finish_test();
    end
endmodule : hotswap_protect_sense_cfg_tb
